//--- hw/lbg_consts.vh
`ifndef LBG_CONSTS_VH
`define LBG_CONSTS_VH
// ==========================================================
// Register offsets (byte addresses on APB)
`define LBG_OFS_CTRL 12'h000
`define LBG_OFS_STAT 12'h004
`define LBG_OFS_PDATA 12'h008
`define LBG_OFS_PSEL 12'h00C
// ==========================================================
// Control register fields and reset value
`define LBG_CTRL_RUN_BIT 0
`define LBG_CTRL_RESET 32'h00000000
// ==========================================================
// Status register fields
`define LBG_STAT_IRQ_BIT 0
`define LBG_STAT_INRST_BIT 1
`define LBG_STAT_RSTOK_BIT 2
`define LBG_STAT_MEMORY_ERROR_FLAG_BIT 3
// ==========================================================
// Timing
`define LBG_CLK_PERIOD_NS 100
`define LBG_RST_MIN_NS 200
`define LBG_MEMERR_NS 25600000
`define LBG_RST_MIN_CYCLES ((`LBG_RST_MIN_NS + `LBG_CLK_PERIOD_NS - 1) / `LBG_CLK_PERIOD_NS)
`define LBG_MEMERR_CYCLES (`LBG_MEMERR_NS / `LBG_CLK_PERIOD_NS)
// ==========================================================
// Address window and ring geometry
`define LBG_CTL_ADDR_W 24
`define LBG_RING_ENTRIES 128
`endif

//--- hw/lbg_lan_glue.v
// Functional notes
// R01 - Controller reaches only lowest 16 Mbytes
// R02 - Software keeps LAN region uncached, unswapped
// R03 - Structures stored big-endian like the CPU
// R04 - Ownership bit grants each ring element
// R05 - One transmit, one receive ring, 128 each
// R06 - Descriptors four half-words, 8-byte aligned, contiguous
// R07 - Software reserves 16 KB buffers, 2 KB rings
// R08 - Init block even address, in address registers
// R09 - Data buffers half-word aligned in low memory
// R10 - Reset bit zero resets interface, 200 ns
// R11 - In reset, slave port idle, registers inaccessible
// R12 - Reset clears pointer, sets stop flag only
// R13 - Software rewrites address and config registers
// R14 - Software writes 0x0004 to bus config
// R15 - Init, wait init done, then start
// R16 - CPU interrupt follows controller interrupt output
// R17 - Controller interrupts; memory error after 25.6 ms
// R18 - Software clears interrupt at the controller
// R19 - Address bits 31-24 zero, 23-0 passed
// R20 - Byte swap one, latch and byte modes zero
// R21 - Issued bus transactions are non-snooped
// R22 - CPU interrupt is a level, never latched
// R23 - Controller reset follows reset bit same cycle
//
// The register offsets and the APB slave port were chosen for this implementation.
`include "lbg_consts.vh"
`default_nettype none
module lbg_lan_glue #(
    parameter ADDR_W = 12,
    parameter MEMERR_CYCLES = `LBG_MEMERR_CYCLES,
    parameter RING_ENTRIES = `LBG_RING_ENTRIES
) (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Controller register port
    output reg ctlRegSel,
    output reg ctlRegWrite,
    output reg ctlRegPtrSel,
    output reg [15:0] ctlRegWdata,
    input wire [15:0] ctlRegRdata,
    input wire ctlRegAck,
    // Controller reset and interrupt
    output wire ctlReset,
    input wire ctlIrq_n,
    output wire cpuIrq,
    // Controller DMA side
    input wire ctlDmaReq,
    input wire ctlDmaWrite,
    input wire [`LBG_CTL_ADDR_W-1:0] ctlDmaAddr,
    input wire [1:0] ctlDmaByteEn,
    input wire [15:0] ctlDmaWdata,
    output reg ctlDmaAck,
    output reg ctlDmaErr,
    output reg [15:0] ctlDmaRdata,
    // System bus master side
    output reg sysReq,
    output reg sysWrite,
    output reg [31:0] sysAddr,
    output reg [3:0] sysByteEn,
    output reg [31:0] sysWdata,
    output wire sysSnoop,
    input wire sysAck,
    input wire [31:0] sysRdata
);
    // ==========================================================
    // Local declarations
    localparam PS_IDLE = 2'd0;
    localparam PS_BUSY = 2'd1;
    localparam PS_DONE = 2'd2;
    localparam DS_IDLE = 1'b0;
    localparam DS_BUSY = 1'b1;
    // Descriptor ring span in bytes, eight bytes per entry
    localparam RING_BYTES = RING_ENTRIES * 8; // [R05] [R06]
    // Full-width copies so that fields are cut out on purpose
    localparam [31:0] CTRL_RESET = `LBG_CTRL_RESET;
    localparam [31:0] RST_MIN_FULL = `LBG_RST_MIN_CYCLES;
    reg run_reg; // Subsystem run bit, zero holds reset
    reg memory_error_flag_reg; // Sticky memory error
    reg [1:0] rstCnt_reg; // Cycles spent in subsystem reset
    reg [1:0] pState_reg;
    reg [1:0] pState_next;
    reg dState_reg;
    reg [31:0] timer_reg; // Wait cycles on the system bus
    wire inReset;
    wire setup;
    wire access;
    wire merrEvent;
    wire [1:0] rstMin;

    // ==========================================================
    // Address decode helpers
    // Access targets the controller's register port
    function isPort;
        input [ADDR_W-1:0] a;
        begin
            isPort = (a == `LBG_OFS_PDATA) || (a == `LBG_OFS_PSEL);
        end
    endfunction

    // Access targets any mapped offset
    function isMapped;
        input [ADDR_W-1:0] a;
        begin
            isMapped = isPort(a) || (a == `LBG_OFS_CTRL) || (a == `LBG_OFS_STAT);
        end
    endfunction

    // ==========================================================
    // Reset and interrupt glue
    assign inReset = ~run_reg;
    assign ctlReset = inReset; // [R23] [R10] [R12]
    assign cpuIrq = ~ctlIrq_n; // [R16] [R22]
    assign sysSnoop = 1'b0; // [R21]
    assign rstMin = RST_MIN_FULL[1:0];

    // Count cycles in reset so software can see 200 ns has passed
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstCnt_reg <= 2'h0;
        end else if (!inReset) begin
            rstCnt_reg <= 2'h0;
        end else if (rstCnt_reg != rstMin) begin
            rstCnt_reg <= rstCnt_reg + 2'h1; // [R10]
        end
    end

    // ==========================================================
    // APB slave
    assign setup = psel & ~penable;
    assign access = psel & penable;
    // Port accesses during reset are refused at once with an error
    assign pready = access & (~isPort(paddr) | inReset | (pState_reg == PS_DONE));
    assign pslverr = pready & (~isMapped(paddr) | (isPort(paddr) & inReset)); // [R11]
    assign merrEvent = (dState_reg == DS_BUSY) & ~sysAck & (timer_reg >= MEMERR_CYCLES - 1);

    // Control and sticky status; a new memory error beats the clear
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_reg <= CTRL_RESET[`LBG_CTRL_RUN_BIT];
            memory_error_flag_reg <= 1'b0;
        end else begin
            if (access && pwrite && paddr == `LBG_OFS_CTRL) begin
                run_reg <= pwdata[`LBG_CTRL_RUN_BIT]; // [R10]
            end
            if (merrEvent) begin
                memory_error_flag_reg <= 1'b1; // [R17]
            end else if (access && pwrite && paddr == `LBG_OFS_STAT &&
                         pwdata[`LBG_STAT_MEMORY_ERROR_FLAG_BIT]) begin
                memory_error_flag_reg <= 1'b0;
            end
        end
    end

    // Read data loaded in the setup phase or on the port answer
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= 32'h00000000;
            if (paddr == `LBG_OFS_CTRL) begin
                prdata[`LBG_CTRL_RUN_BIT] <= run_reg;
            end else if (paddr == `LBG_OFS_STAT) begin
                prdata[`LBG_STAT_IRQ_BIT] <= cpuIrq;
                prdata[`LBG_STAT_INRST_BIT] <= inReset;
                prdata[`LBG_STAT_RSTOK_BIT] <= inReset & (rstCnt_reg == rstMin);
                prdata[`LBG_STAT_MEMORY_ERROR_FLAG_BIT] <= memory_error_flag_reg;
            end
        end else if (pState_reg == PS_BUSY && ctlRegAck) begin
            prdata <= {16'h0000, ctlRegRdata};
        end
    end

    // ==========================================================
    // Controller register port sequencer
    always @* begin
        pState_next = pState_reg;
        case (pState_reg)
            PS_IDLE: begin
                if (setup && isPort(paddr)) begin
                    pState_next = PS_BUSY;
                end
            end
            PS_BUSY: begin
                if (ctlRegAck) begin
                    pState_next = PS_DONE;
                end
            end
            PS_DONE: begin
                pState_next = PS_IDLE;
            end
            default: begin
                pState_next = PS_IDLE;
            end
        endcase
        if (inReset) begin
            pState_next = PS_IDLE; // [R11]
        end
    end

    // State and strobes toward the controller's register port
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pState_reg <= PS_IDLE;
            ctlRegSel <= 1'b0;
            ctlRegWrite <= 1'b0;
            ctlRegPtrSel <= 1'b0;
            ctlRegWdata <= 16'h0000;
        end else begin
            pState_reg <= pState_next;
            ctlRegSel <= (pState_next == PS_BUSY);
            if (pState_reg == PS_IDLE && pState_next == PS_BUSY) begin
                ctlRegWrite <= pwrite;
                ctlRegPtrSel <= (paddr == `LBG_OFS_PSEL);
                ctlRegWdata <= pwdata[15:0];
            end
        end
    end

    // ==========================================================
    // DMA bridge from controller to system bus
    // One half-word per transfer, held whole until answered, timed out or reset
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dState_reg <= DS_IDLE;
            timer_reg <= 32'h00000000;
            sysReq <= 1'b0;
            sysWrite <= 1'b0;
            sysAddr <= 32'h00000000;
            sysByteEn <= 4'h0;
            sysWdata <= 32'h00000000;
            ctlDmaAck <= 1'b0;
            ctlDmaErr <= 1'b0;
            ctlDmaRdata <= 16'h0000;
        end else begin
            ctlDmaAck <= 1'b0;
            ctlDmaErr <= 1'b0;
            case (dState_reg)
                DS_IDLE: begin
                    if (ctlDmaReq && !inReset && !ctlDmaAck && !ctlDmaErr) begin
                        dState_reg <= DS_BUSY;
                        timer_reg <= 32'h00000000;
                        sysReq <= 1'b1; // [R04]
                        sysWrite <= ctlDmaWrite;
                        sysAddr <= {8'h00, ctlDmaAddr}; // [R19] [R01]
                        // Even half-word sits in the high lanes
                        sysByteEn <= ctlDmaAddr[1] ? {2'b00, ctlDmaByteEn} :
                                                     {ctlDmaByteEn, 2'b00}; // [R03]
                        sysWdata <= {ctlDmaWdata, ctlDmaWdata}; // [R03]
                    end
                end
                DS_BUSY: begin
                    timer_reg <= timer_reg + 32'h00000001;
                    if (inReset) begin
                        dState_reg <= DS_IDLE; // [R11]
                        sysReq <= 1'b0;
                    end else if (sysAck) begin
                        dState_reg <= DS_IDLE;
                        sysReq <= 1'b0;
                        ctlDmaAck <= 1'b1;
                        ctlDmaRdata <= sysAddr[1] ? sysRdata[15:0] : sysRdata[31:16]; // [R03]
                    end else if (merrEvent) begin
                        dState_reg <= DS_IDLE; // [R17]
                        sysReq <= 1'b0;
                        ctlDmaErr <= 1'b1;
                    end
                end
                default: begin
                    dState_reg <= DS_IDLE;
                end
            endcase
        end
    end
endmodule // lbg_lan_glue
`default_nettype wire

//--- testbench/lbg_lan_glue_assertions.sv
`default_nettype none
// ==========================================
// Bus glue checker
module lbg_lan_glue_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controller side
    input wire logic ctlRegSel,
    input wire logic ctlReset,
    input wire logic ctlIrq_n,
    input wire logic cpuIrq,
    input wire logic [23:0] ctlDmaAddr,
    // System bus
    input wire logic sysReq,
    input wire logic [31:0] sysAddr,
    input wire logic sysSnoop
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    addr_top_zero_a:
        assert property (sysReq |-> sysAddr[31:24] == 8'h00) else $error("high address bits set");
    addr_pass_a:
        assert property ($rose(sysReq) |-> sysAddr[23:1] == $past(ctlDmaAddr[23:1]))
        else $error("address not passed through");
    no_snoop_a:
        assert property (sysSnoop == 1'b0) else $error("snoop requested");
    irq_follow_a:
        assert property (cpuIrq == !ctlIrq_n) else $error("cpu interrupt wrong");
    irq_drop_a:
        assert property ($fell(cpuIrq) |-> $rose(ctlIrq_n)) else $error("interrupt latched");
    run_write_a:
        assert property (psel && penable && pready && pwrite && paddr == 12'h000
            |=> ctlReset == !$past(pwdata[0])) else $error("controller reset wrong");
    port_refuse_a:
        assert property (psel && penable && ctlReset && paddr[11:3] == 9'h001
            |-> pready && pslverr) else $error("port open in reset");
    idle_in_reset_a:
        assert property (ctlReset && $past(ctlReset) |-> !sysReq && !ctlRegSel)
        else $error("activity in reset");
endmodule // lbg_lan_glue_assertions
bind lbg_lan_glue lbg_lan_glue_assertions i_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .ctlRegSel(ctlRegSel), .ctlReset(ctlReset), .ctlIrq_n(ctlIrq_n), .cpuIrq(cpuIrq),
    .ctlDmaAddr(ctlDmaAddr), .sysReq(sysReq), .sysAddr(sysAddr), .sysSnoop(sysSnoop));
`default_nettype wire

//--- testbench/lbg_ctl_model.sv
`default_nettype none
// ==========================================
// Controller and memory stand-in
module lbg_ctl_model (
    // Clock and bench control
    input wire logic ref_clk,
    input wire logic [4:0] memDelay,
    // Controller register port
    input wire logic ctlReset,
    input wire logic ctlRegSel,
    input wire logic ctlRegWrite,
    input wire logic ctlRegPtrSel,
    input wire logic [15:0] ctlRegWdata,
    output logic [15:0] ctlRegRdata,
    output logic ctlRegAck,
    // System memory
    input wire logic sysReq,
    input wire logic [31:0] sysAddr,
    output logic sysAck,
    output logic [31:0] sysRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] regs [0:3]; // Status, address words, bus config
    logic [1:0] ptr; // Register select pointer
    logic [15:0] held; // Last answer
    logic [4:0] cnt = 5'h00; // Memory wait count
    // Released lines show the inverse value
    assign ctlRegRdata = ctlRegAck ? held : ~held;
    assign sysRdata = sysAck ? {sysAddr[15:0], ~sysAddr[15:0]} : {~sysAddr[15:0], sysAddr[15:0]};
    // Register port, one access at a time
    always @(posedge ref_clk) begin
        if (ctlReset) begin
            ptr <= 2'h0;
            regs[0] <= 16'h0004;
            ctlRegAck <= 1'b0;
        end else if (ctlRegSel && !ctlRegAck) begin
            ctlRegAck <= 1'b1;
            held <= ctlRegPtrSel ? {14'h0000, ptr} : regs[ptr];
            if (ctlRegWrite && ctlRegPtrSel) ptr <= ctlRegWdata[1:0];
            // An init command in the status word reports init done at once
            if (ctlRegWrite && !ctlRegPtrSel)
                regs[ptr] <= ctlRegWdata | {7'h00, ptr == 2'h0 && ctlRegWdata[0], 8'h00};
        end else if (!ctlRegSel) begin
            ctlRegAck <= 1'b0;
        end
    end
    // Memory answers after memDelay cycles
    always @(posedge ref_clk) begin
        sysAck <= sysReq && !sysAck && cnt == memDelay;
        cnt <= (sysReq && !sysAck) ? cnt + 5'h01 : 5'h00;
    end
endmodule // lbg_ctl_model
`default_nettype wire

//--- testbench/lbg_lan_glue_tb.sv
`include "lbg_consts.vh"
`default_nettype none
// ==========================================
// Bench top
module lbg_lan_glue_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, sysAddr, sysWdata, sysRdata, rd, d;
    logic pready, pslverr, ctlRegSel, ctlRegWrite, ctlRegPtrSel, ctlRegAck, ctlReset, er;
    logic [15:0] ctlRegWdata, ctlRegRdata, ctlDmaRdata, ctlDmaWdata = 16'h0;
    logic ctlIrq_n = 1'b1, ctlDmaReq = 1'b0, ctlDmaWrite = 1'b0, ctlDmaAck, ctlDmaErr, cpuIrq;
    logic [23:0] ctlDmaAddr = 24'h0, a;
    logic [1:0] ctlDmaByteEn = 2'h3;
    logic sysReq, sysWrite, sysSnoop, sysAck;
    logic [3:0] sysByteEn;
    logic [4:0] memDelay = 5'h00;
    integer mismatches = 0, checks_done = 0, seed = 32'hbdc6, i;
    lbg_lan_glue #(.MEMERR_CYCLES(20)) i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctlRegSel(ctlRegSel), .ctlRegWrite(ctlRegWrite), .ctlRegPtrSel(ctlRegPtrSel),
        .ctlRegWdata(ctlRegWdata), .ctlRegRdata(ctlRegRdata), .ctlRegAck(ctlRegAck),
        .ctlReset(ctlReset), .ctlIrq_n(ctlIrq_n), .cpuIrq(cpuIrq),
        .ctlDmaReq(ctlDmaReq), .ctlDmaWrite(ctlDmaWrite), .ctlDmaAddr(ctlDmaAddr),
        .ctlDmaByteEn(ctlDmaByteEn), .ctlDmaWdata(ctlDmaWdata), .ctlDmaAck(ctlDmaAck),
        .ctlDmaErr(ctlDmaErr), .ctlDmaRdata(ctlDmaRdata), .sysReq(sysReq),
        .sysWrite(sysWrite), .sysAddr(sysAddr), .sysByteEn(sysByteEn), .sysWdata(sysWdata),
        .sysSnoop(sysSnoop), .sysAck(sysAck), .sysRdata(sysRdata));
    lbg_ctl_model i_model (
        .ref_clk(ref_clk), .memDelay(memDelay), .ctlReset(ctlReset), .ctlRegSel(ctlRegSel),
        .ctlRegWrite(ctlRegWrite), .ctlRegPtrSel(ctlRegPtrSel), .ctlRegWdata(ctlRegWdata),
        .ctlRegRdata(ctlRegRdata), .ctlRegAck(ctlRegAck), .sysReq(sysReq),
        .sysAddr(sysAddr), .sysAck(sysAck), .sysRdata(sysRdata));
    always #50 ref_clk = ~ref_clk;
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, answer taken at the edge with pready
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Values read here are those sampled at this rising edge
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Data lane picked by half-word address
    function automatic logic [15:0] lane_of(input logic [23:0] ad);
        return ad[1] ? ~ad[15:0] : ad[15:0];
    endfunction
    task automatic complete_run;
        if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    initial begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        apb(1'b0, `LBG_OFS_STAT, 32'h0);
        check(rd[`LBG_STAT_INRST_BIT], 1'b1);
        check(ctlReset, 1'b1);
        apb(1'b1, `LBG_OFS_PDATA, 32'h0);
        check(er, 1'b1);
        apb(1'b1, `LBG_OFS_CTRL, 32'h1);
        @(negedge ref_clk);
        check(ctlReset, 1'b0);
        apb(1'b0, `LBG_OFS_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, `LBG_OFS_PSEL, 32'h0);
        check(rd, 32'h0);
        check(er, 1'b0);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `LBG_OFS_PSEL, i);
            apb(1'b0, `LBG_OFS_PDATA, 32'h0);
            if (i == 0) check(rd, 32'h4);
            d = (i == 3) ? 32'h4 : ($random(seed) & 32'hFFFE);
            apb(1'b1, `LBG_OFS_PDATA, d);
            apb(1'b0, `LBG_OFS_PDATA, 32'h0);
            check(rd, d);
        end
        // Init command, init-done poll, then start command
        apb(1'b1, `LBG_OFS_PSEL, 32'h0);
        apb(1'b1, `LBG_OFS_PDATA, 32'h1);
        apb(1'b0, `LBG_OFS_PDATA, 32'h0);
        check(rd[8], 1'b1);
        apb(1'b1, `LBG_OFS_PDATA, 32'h2);
        @(posedge ref_clk);
        ctlIrq_n <= 1'b0;
        apb(1'b0, `LBG_OFS_STAT, 32'h0);
        check(rd[`LBG_STAT_IRQ_BIT], 1'b1);
        ctlIrq_n <= 1'b1;
        @(negedge ref_clk);
        check(cpuIrq, 1'b0);
        for (i = 0; i < 9; i++) begin
            @(posedge ref_clk);
            d = $random(seed);
            // Odd passes hit descriptors, even passes half-word buffers, all in low memory
            a = d[23:0] & (i[0] ? 24'hFFFFF8 : 24'hFFFFFE);
            memDelay <= (i == 8) ? 5'h1F : {2'b00, d[28:26]};
            ctlDmaAddr <= a;
            ctlDmaWrite <= d[29];
            ctlDmaByteEn <= d[31:30];
            ctlDmaWdata <= d[31:16];
            ctlDmaReq <= 1'b1;
            // Answer taken at the rising edge where the pulse is sampled
            do @(posedge ref_clk); while (ctlDmaAck !== 1'b1 && ctlDmaErr !== 1'b1);
            if (i < 8) check(ctlDmaRdata, lane_of(a));
            else check(ctlDmaErr, 1'b1);
            check(sysAddr, {8'h00, a});
            check(sysWrite, d[29]);
            check(sysByteEn, a[1] ? {2'b00, d[31:30]} : {d[31:30], 2'b00});
            check(sysWdata, {d[31:16], d[31:16]});
            ctlDmaReq <= 1'b0;
        end
        apb(1'b0, `LBG_OFS_STAT, 32'h0);
        check(rd[`LBG_STAT_MEMORY_ERROR_FLAG_BIT], 1'b1);
        apb(1'b1, `LBG_OFS_STAT, 32'h8);
        apb(1'b0, `LBG_OFS_STAT, 32'h0);
        check(rd[`LBG_STAT_MEMORY_ERROR_FLAG_BIT], 1'b0);
        apb(1'b1, `LBG_OFS_CTRL, 32'h0);
        apb(1'b0, `LBG_OFS_STAT, 32'h0);
        check(rd[`LBG_STAT_RSTOK_BIT], 1'b0);
        repeat (2) @(posedge ref_clk);
        apb(1'b0, `LBG_OFS_STAT, 32'h0);
        check(rd[`LBG_STAT_RSTOK_BIT], 1'b1);
        apb(1'b0, `LBG_OFS_PSEL, 32'h0);
        check(er, 1'b1);
        apb(1'b1, `LBG_OFS_CTRL, 32'h1);
        apb(1'b0, `LBG_OFS_PSEL, 32'h0);
        check(rd, 32'h0);
        complete_run;
    end
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        complete_run;
    end
endmodule // lbg_lan_glue_tb
`default_nettype wire
